// File: rtl/srwg_pkg.sv
// package of constants and carrier types for the supervisor reset and write guard
package srwg_pkg;

    // clock rate and reset hold times, one per timeout select code
    localparam int CLK_MHZ = 25;
    localparam int HOLD_TIME_US_0 = 50;
    localparam int HOLD_TIME_US_1 = 100;
    localparam int HOLD_TIME_US_2 = 200;
    localparam int HOLD_TIME_US_3 = 400;
    localparam int HOLD_CNT_W = 16;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] INT_STAT_OFF = 8'h08;
    localparam logic [7:0] INT_CLR_OFF = 8'h0C;
    localparam logic [7:0] INT_EN_OFF = 8'h10;
    localparam int ADDR_W = 8;

    // control register fields
    localparam int CTRL_SEL_LO = 0;
    localparam int CTRL_SEL_HI = 1;
    localparam int CTRL_REGION_LSB = 2;
    localparam int CTRL_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

    // status register fields
    localparam int STAT_RESET = 0;
    localparam int STAT_MON2 = 1;
    localparam int STAT_MON3 = 2;
    localparam int STAT_WP = 3;
    localparam int STAT_SUPPLY = 4;
    localparam int STAT_MANUAL = 5;
    localparam int STAT_W = 6;

    // interrupt event bits
    localparam int EV_RESET_ON = 0;
    localparam int EV_RESET_OFF = 1;
    localparam int EV_MON2 = 2;
    localparam int EV_MON3 = 3;
    localparam int EV_REFUSED = 4;
    localparam int EV_W = 5;
    localparam logic [EV_W-1:0] EV_RST = 5'h00;

    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // comparator results from the analog side
    typedef struct packed {
        logic supply_ok;
        logic monitor2_sense_in;
        logic monitor3_sense_in;
    } srwg_sense_s;

    // write requests from the serial/command side, one-cycle pulses
    typedef struct packed {
        logic nv_req;
        logic vol_req;
    } srwg_wreq_s;

    typedef enum logic [0:0] {
        ST_HOLD,
        ST_RUN
    } srwg_state_e;

endpackage

// File: rtl/srwg_top.sv
// supervisor reset sequencer, monitor pass-through and write guard with apb registers
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module srwg_top #(
    parameter int HOLD_CYCLES_0 = srwg_pkg::HOLD_TIME_US_0 * srwg_pkg::CLK_MHZ,
    parameter int HOLD_CYCLES_1 = srwg_pkg::HOLD_TIME_US_1 * srwg_pkg::CLK_MHZ,
    parameter int HOLD_CYCLES_2 = srwg_pkg::HOLD_TIME_US_2 * srwg_pkg::CLK_MHZ,
    parameter int HOLD_CYCLES_3 = srwg_pkg::HOLD_TIME_US_3 * srwg_pkg::CLK_MHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic manual_reset_in,
    input wire logic write_protect_in,
    input wire srwg_pkg::srwg_sense_s sense_in,
    input wire srwg_pkg::srwg_wreq_s wreq_in,
    output logic supply_reset_out,
    output logic monitor2_fail_out,
    output logic monitor3_fail_out,
    output logic nv_write_ok,
    output logic vol_write_ok,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    srwg_pkg::srwg_state_e state_q, state_d;
    logic [srwg_pkg::HOLD_CNT_W-1:0] hold_cnt_q, hold_cnt_d;
    logic rst_out_q, rst_out_d;
    logic mon2_q, mon2_d;
    logic mon3_q, mon3_d;
    logic nv_ok_q, nv_ok_d;
    logic vol_ok_q, vol_ok_d;
    logic [srwg_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [srwg_pkg::EV_W-1:0] int_stat_q, int_stat_d;
    logic [srwg_pkg::EV_W-1:0] int_en_q, int_en_d;
    logic irq_q, irq_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;

    logic src_active;
    logic [srwg_pkg::HOLD_CNT_W-1:0] reload;
    logic [1:0] region;
    logic [srwg_pkg::EV_W-1:0] events;
    logic setup, wr_take, mapped;
    logic [srwg_pkg::ADDR_W-1:0] addr;

    // hold count minus one for each select code
    function automatic logic [srwg_pkg::HOLD_CNT_W-1:0] hold_load(input logic [1:0] sel);
        logic [srwg_pkg::HOLD_CNT_W-1:0] v;
        case (sel)
            2'h0: v = srwg_pkg::HOLD_CNT_W'(HOLD_CYCLES_0 - 1);
            2'h1: v = srwg_pkg::HOLD_CNT_W'(HOLD_CYCLES_1 - 1);
            2'h2: v = srwg_pkg::HOLD_CNT_W'(HOLD_CYCLES_2 - 1);
            default: v = srwg_pkg::HOLD_CNT_W'(HOLD_CYCLES_3 - 1);
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset sequencer

    // any reset source: manual pin or supply under its trip level
    assign src_active = manual_reset_in | ~sense_in.supply_ok;
    // select bits are read live, so a change affects the next reload only
    assign reload = hold_load(ctrl_q[srwg_pkg::CTRL_SEL_HI:srwg_pkg::CTRL_SEL_LO]);

    // next state of the hold counter and reset output
    always_comb begin
        state_d = state_q;
        hold_cnt_d = hold_cnt_q;
        rst_out_d = rst_out_q;
        case (state_q)
            srwg_pkg::ST_HOLD: begin
                rst_out_d = 1'b1;
                if (src_active) begin
                    hold_cnt_d = reload;
                end else if (hold_cnt_q == '0) begin
                    state_d = srwg_pkg::ST_RUN;
                    rst_out_d = 1'b0;
                end else begin
                    hold_cnt_d = hold_cnt_q - 1'b1;
                end
            end
            srwg_pkg::ST_RUN: begin
                if (src_active) begin
                    state_d = srwg_pkg::ST_HOLD;
                    rst_out_d = 1'b1;
                    hold_cnt_d = reload;
                end
            end
            default: begin
                state_d = srwg_pkg::ST_HOLD;
                rst_out_d = 1'b1;
                hold_cnt_d = reload;
            end
        endcase
    end

    // reset out of power-up starts in hold with the default select code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= srwg_pkg::ST_HOLD;
            hold_cnt_q <= srwg_pkg::HOLD_CNT_W'(HOLD_CYCLES_0 - 1);
            rst_out_q <= 1'b1;
        end else begin
            state_q <= state_d;
            hold_cnt_q <= hold_cnt_d;
            rst_out_q <= rst_out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // monitors and write guard

    // one flop only, required to keep outputs registered; no stretching
    assign region = ctrl_q[srwg_pkg::CTRL_REGION_LSB +: 2];

    always_comb begin
        mon2_d = sense_in.monitor2_sense_in;
        mon3_d = sense_in.monitor3_sense_in;
        // pad pull-down: low write protect leaves writes open
        nv_ok_d = wreq_in.nv_req & ~write_protect_in;
        vol_ok_d = wreq_in.vol_req & ~(write_protect_in & (region != 2'h0));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon2_q <= 1'b0;
            mon3_q <= 1'b0;
            nv_ok_q <= 1'b0;
            vol_ok_q <= 1'b0;
        end else begin
            mon2_q <= mon2_d;
            mon3_q <= mon3_d;
            nv_ok_q <= nv_ok_d;
            vol_ok_q <= vol_ok_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave and interrupts

    assign addr = paddr[srwg_pkg::ADDR_W-1:0];
    assign setup = psel & ~penable;
    // a write lands only at the completing access edge
    assign wr_take = psel & penable & pready_q & pwrite;
    assign mapped = (paddr[31:srwg_pkg::ADDR_W] == '0) &&
                    (addr == srwg_pkg::CTRL_OFF || addr == srwg_pkg::STATUS_OFF ||
                     addr == srwg_pkg::INT_STAT_OFF || addr == srwg_pkg::INT_CLR_OFF ||
                     addr == srwg_pkg::INT_EN_OFF);

    // event pulses, taken from the next values of the registered outputs
    always_comb begin
        events = '0;
        events[srwg_pkg::EV_RESET_ON] = rst_out_d & ~rst_out_q;
        events[srwg_pkg::EV_RESET_OFF] = ~rst_out_d & rst_out_q;
        events[srwg_pkg::EV_MON2] = mon2_d ^ mon2_q;
        events[srwg_pkg::EV_MON3] = mon3_d ^ mon3_q;
        events[srwg_pkg::EV_REFUSED] = (wreq_in.nv_req & ~nv_ok_d) | (wreq_in.vol_req & ~vol_ok_d);
    end

    // register file; a new event wins over a clear in the same cycle
    always_comb begin
        ctrl_d = ctrl_q;
        int_en_d = int_en_q;
        int_stat_d = int_stat_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        pready_d = setup; // answer one cycle after setup
        if (wr_take && mapped) begin
            case (addr)
                srwg_pkg::CTRL_OFF: ctrl_d = pwdata[srwg_pkg::CTRL_W-1:0];
                srwg_pkg::INT_CLR_OFF: int_stat_d = int_stat_q & ~pwdata[srwg_pkg::EV_W-1:0];
                srwg_pkg::INT_EN_OFF: int_en_d = pwdata[srwg_pkg::EV_W-1:0];
                default: int_stat_d = int_stat_q;
            endcase
        end
        int_stat_d = int_stat_d | events;
        if (setup) begin
            prdata_d = srwg_pkg::DATA_ZERO;
            pslverr_d = ~mapped;
            if (!pwrite) begin
                case (addr)
                    srwg_pkg::CTRL_OFF: prdata_d[srwg_pkg::CTRL_W-1:0] = ctrl_q;
                    srwg_pkg::STATUS_OFF: begin
                        prdata_d[srwg_pkg::STAT_RESET] = rst_out_q;
                        prdata_d[srwg_pkg::STAT_MON2] = mon2_q;
                        prdata_d[srwg_pkg::STAT_MON3] = mon3_q;
                        prdata_d[srwg_pkg::STAT_WP] = write_protect_in;
                        prdata_d[srwg_pkg::STAT_SUPPLY] = sense_in.supply_ok;
                        prdata_d[srwg_pkg::STAT_MANUAL] = manual_reset_in;
                    end
                    srwg_pkg::INT_STAT_OFF: prdata_d[srwg_pkg::EV_W-1:0] = int_stat_q;
                    srwg_pkg::INT_EN_OFF: prdata_d[srwg_pkg::EV_W-1:0] = int_en_q;
                    default: prdata_d = srwg_pkg::DATA_ZERO;
                endcase
            end
        end
        irq_d = |(int_stat_d & int_en_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= srwg_pkg::CTRL_RST;
            int_en_q <= srwg_pkg::EV_RST;
            int_stat_q <= srwg_pkg::EV_RST;
            irq_q <= 1'b0;
            prdata_q <= srwg_pkg::DATA_ZERO;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            int_en_q <= int_en_d;
            int_stat_q <= int_stat_d;
            irq_q <= irq_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // outputs straight from flops
    assign supply_reset_out = rst_out_q;
    assign monitor2_fail_out = mon2_q;
    assign monitor3_fail_out = mon3_q;
    assign nv_write_ok = nv_ok_q;
    assign vol_write_ok = vol_ok_q;
    assign irq = irq_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence src_drop_s;
        src_active ##1 !src_active;
    endsequence

    sequence quiet_s;
        !src_active [*3];
    endsequence

    manual_reset_a: assert property (manual_reset_in |=> supply_reset_out)
        else $error("manual reset did not raise supply reset");

    manual_hold_a: assert property (src_drop_s ##0 quiet_s |-> supply_reset_out)
        else $error("supply reset released too soon after source");

    reload_sel_a: assert property (src_active |=>
        hold_cnt_q == hold_load($past(ctrl_q[srwg_pkg::CTRL_SEL_HI:srwg_pkg::CTRL_SEL_LO])))
        else $error("hold counter not loaded from select bits");

    hold_active_a: assert property (state_q == srwg_pkg::ST_HOLD |-> supply_reset_out)
        else $error("reset low while still holding");

    supply_low_a: assert property (!sense_in.supply_ok |=> supply_reset_out ##0 state_q == srwg_pkg::ST_HOLD)
        else $error("low supply did not assert reset");

    mon2_follow_a: assert property (monitor2_fail_out == $past(sense_in.monitor2_sense_in))
        else $error("monitor2 fail does not follow comparator");

    mon3_follow_a: assert property ($changed(sense_in.monitor3_sense_in) |=>
        $changed(monitor3_fail_out) && monitor3_fail_out == $past(sense_in.monitor3_sense_in))
        else $error("monitor3 fail missed a comparator change");

    nv_refuse_a: assert property (write_protect_in && wreq_in.nv_req |=> !nv_write_ok)
        else $error("nonvolatile write allowed under protect");

    vol_block_a: assert property (write_protect_in && region != 2'h0 && wreq_in.vol_req
        |=> !vol_write_ok ##0 int_stat_q[srwg_pkg::EV_REFUSED])
        else $error("volatile write allowed under locked region");

    wp_low_a: assert property (!write_protect_in && wreq_in.nv_req |=> nv_write_ok)
        else $error("write refused with protect low");

    release_term_a: assert property ($fell(supply_reset_out) |->
        $past(hold_cnt_q) == '0 && !$past(src_active))
        else $error("reset released before terminal count");

endmodule
`default_nettype wire

// File: sim/srwg_host_model.sv
// board-side model: manual reset and write protect pins
`timescale 1ns/1ns
`default_nettype none
module srwg_host_model (
    input wire logic mr_en,
    input wire logic mr_val,
    input wire logic wp_en,
    input wire logic wp_val,
    output logic manual_reset_in,
    output logic write_protect_in
);
    // released pins sit at the pull-down level, never the last value
    assign manual_reset_in = mr_en ? mr_val : 1'b0;
    assign write_protect_in = wp_en ? wp_val : 1'b0;
endmodule
`default_nettype wire

// File: sim/srwg_tb_top.sv
// self-checking bench for the supervisor reset and write guard
`timescale 1ns/1ns
`default_nettype none
module srwg_tb_top;
    // short hold counts keep the run small
    localparam int HC [4] = '{4, 6, 8, 10};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mr_en = 1'b0;
    logic mr_val = 1'b0;
    logic wp_en = 1'b0;
    logic wp_val = 1'b0;
    logic mr_pin;
    logic wp_pin;
    srwg_pkg::srwg_sense_s sense = 3'h4;
    srwg_pkg::srwg_wreq_s wreq = 2'h0;
    logic rst_o;
    logic m2;
    logic m3;
    logic nv_ok;
    logic vol_ok;
    logic irq;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int checks = 0;

    ////////////////////////////////////////
    srwg_top #(.HOLD_CYCLES_0(HC[0]), .HOLD_CYCLES_1(HC[1]), .HOLD_CYCLES_2(HC[2]), .HOLD_CYCLES_3(HC[3])) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .manual_reset_in(mr_pin), .write_protect_in(wp_pin), .sense_in(sense), .wreq_in(wreq),
        .supply_reset_out(rst_o), .monitor2_fail_out(m2), .monitor3_fail_out(m3),
        .nv_write_ok(nv_ok), .vol_write_ok(vol_ok), .irq(irq));
    srwg_host_model host (.mr_en(mr_en), .mr_val(mr_val), .wp_en(wp_en), .wp_val(wp_val),
        .manual_reset_in(mr_pin), .write_protect_in(wp_pin));

    // 25 mhz clock
    always #20 pclk = ~pclk;

    ////////////////////////////////////////
    // compare and bus tasks
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    // idle edge first, so release and next setup never share a time step
    // no wait limit here: only the watchdog ends a hung transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // edges from the last one that saw a source until reset drops
    task automatic hold_len(input int exp);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (rst_o === 1'b1 && n < 40);
        chk_word(32'(n), 32'(exp));
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        chk_bit(rst_o, 1'b1);
        presetn <= 1'b1;
        hold_len(HC[0]);
        apb(1'b0, srwg_pkg::CTRL_OFF, 32'h0000_0000);
        chk_word(rd, 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk_bit(er, 1'b1);
        // every timeout select code, manual source
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, srwg_pkg::CTRL_OFF, 32'(s));
            apb(1'b0, srwg_pkg::CTRL_OFF, 32'h0000_0000);
            chk_word(rd, 32'(s));
            @(posedge pclk);
            mr_en <= 1'b1;
            mr_val <= 1'b1;
            @(posedge pclk);
            #1 chk_bit(rst_o, 1'b1);
            @(posedge pclk);
            mr_en <= 1'b0;
            hold_len(HC[s]);
        end
        // supply dip, select still 3
        @(posedge pclk);
        sense.supply_ok <= 1'b0;
        repeat (3) @(posedge pclk);
        #1 chk_bit(rst_o, 1'b1);
        @(posedge pclk);
        sense.supply_ok <= 1'b1;
        hold_len(HC[3]);
        // monitors, all four combinations
        for (int v = 0; v < 4; v++) begin
            @(posedge pclk);
            sense.monitor2_sense_in <= v[0];
            sense.monitor3_sense_in <= v[1];
            @(posedge pclk);
            #1 chk_bit(m2, v[0]);
            chk_bit(m3, v[1]);
        end
        // status word: both monitors high, supply good, no reset, no protect
        apb(1'b0, srwg_pkg::STATUS_OFF, 32'h0000_0000);
        chk_word(rd, 32'h0000_0016);
        apb(1'b1, srwg_pkg::INT_CLR_OFF, 32'h0000_001F);
        apb(1'b1, srwg_pkg::INT_EN_OFF, 32'h0000_0010);
        // guard: floating, low, then high with region 0..3
        for (int c = 0; c < 6; c++) begin
            apb(1'b1, srwg_pkg::CTRL_OFF, 32'((c < 2 ? 3 : c - 2) << 2));
            @(posedge pclk);
            wp_en <= c > 0;
            wp_val <= c > 1;
            wreq <= 2'h3;
            @(posedge pclk);
            wreq <= 2'h0;
            #1 chk_bit(nv_ok, c < 2);
            chk_bit(vol_ok, c < 3);
        end
        // refused write raised the interrupt; mask, unmask, clear
        apb(1'b0, srwg_pkg::INT_STAT_OFF, 32'h0000_0000);
        chk_word(rd & 32'h0000_0010, 32'h0000_0010);
        chk_bit(irq, 1'b1);
        apb(1'b1, srwg_pkg::INT_EN_OFF, 32'h0000_0000);
        apb(1'b0, srwg_pkg::INT_EN_OFF, 32'h0000_0000);
        chk_word(rd, 32'h0000_0000);
        chk_bit(irq, 1'b0);
        apb(1'b1, srwg_pkg::INT_EN_OFF, 32'h0000_0010);
        apb(1'b1, srwg_pkg::INT_CLR_OFF, 32'h0000_0010);
        apb(1'b0, srwg_pkg::INT_STAT_OFF, 32'h0000_0000);
        chk_word(rd & 32'h0000_0010, 32'h0000_0000);
        chk_bit(irq, 1'b0);
        wrap_up;
    end

    // watchdog, well past the expected run of under a thousand cycles
    initial begin
        #100000;
        err_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
